// File: logic/gpb_pkg.sv
// Constants, register map and shared types of the general pin function block
package gpb_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_PINS     = 19;
   localparam int ADDR_W       = 8;
   localparam int DATA_W       = 32;
   localparam int CNT_W        = 16;
   localparam int ADC_RAW_W    = 12;
   localparam int INT_W        = 2;
   localparam int PIN_IDX_W    = 5;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_DIR       = 8'h00;
   localparam logic [ADDR_W-1:0] REG_OUT       = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IN        = 8'h08;
   localparam logic [ADDR_W-1:0] REG_DRIVE     = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_PULL_UP   = 8'h10;
   localparam logic [ADDR_W-1:0] REG_PULL_DN   = 8'h14;
   localparam logic [ADDR_W-1:0] REG_WAKE_EN   = 8'h18;
   localparam logic [ADDR_W-1:0] REG_WAKE_POL  = 8'h1c;
   localparam logic [ADDR_W-1:0] REG_PWM_SEL   = 8'h20;
   localparam logic [ADDR_W-1:0] REG_PWM_PER   = 8'h24;
   localparam logic [ADDR_W-1:0] REG_PWM_DUTY  = 8'h28;
   localparam logic [ADDR_W-1:0] REG_SQ_CFG    = 8'h2c;
   localparam logic [ADDR_W-1:0] REG_SQ_PER    = 8'h30;
   localparam logic [ADDR_W-1:0] REG_SQ_DUTY   = 8'h34;
   localparam logic [ADDR_W-1:0] REG_ADC_CTRL  = 8'h38;
   localparam logic [ADDR_W-1:0] REG_ADC_DATA  = 8'h3c;
   localparam logic [ADDR_W-1:0] REG_INT_STAT  = 8'h40;
   localparam logic [ADDR_W-1:0] REG_INT_CLR   = 8'h44;
   localparam logic [ADDR_W-1:0] REG_INT_EN    = 8'h48;
   localparam logic [ADDR_W-1:0] REG_MODE      = 8'h4c;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SQ_A_IDX_LSB   = 0;
   localparam int SQ_A_EN_BIT    = 5;
   localparam int SQ_B_IDX_LSB   = 8;
   localparam int SQ_B_EN_BIT    = 13;
   localparam int SQ_DUTY_B_LSB  = 16;
   localparam int ADC_START_BIT  = 31;
   localparam int INT_WAKE_BIT   = 0;
   localparam int INT_ADC_BIT    = 1;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int RESET_HOLD_MS    = 100;
   localparam int RESET_HOLD_CYC   = RESET_HOLD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PWM_MAX_KHZ      = 1000;
   localparam int PWM_MIN_PER_CYC  = 1000000 / PWM_MAX_KHZ / CLK_PERIOD_NS;
   localparam int SQ_MAX_KHZ       = 4000;
   localparam int SQ_MIN_PER_CYC   = 1000000 / SQ_MAX_KHZ / CLK_PERIOD_NS;
   localparam int ACQ_3_CYC        = 3 * 1000 / CLK_PERIOD_NS;
   localparam int ACQ_5_CYC        = 5 * 1000 / CLK_PERIOD_NS;
   localparam int ACQ_10_CYC       = 10 * 1000 / CLK_PERIOD_NS;
   localparam int ACQ_15_CYC       = 15 * 1000 / CLK_PERIOD_NS;
   localparam int ACQ_20_CYC       = 20 * 1000 / CLK_PERIOD_NS;
   localparam int ACQ_40_CYC       = 40 * 1000 / CLK_PERIOD_NS;
   localparam int STRAP_WAIT_CYC   = 2;
   // ------------------------------------------------------------
   // Encodings and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] ACQ_10_CODE   = 3'h2;
   localparam logic [2:0] GAIN_1_6_CODE = 3'h6;
   localparam logic [1:0] RES_8_CODE    = 2'h0;
   localparam logic [1:0] RES_10_CODE   = 2'h1;
   localparam logic [1:0] RES_12_CODE   = 2'h2;
   localparam logic [2:0] GAIN_MAX_CODE = 3'h6;
   typedef struct packed {
      logic [2:0] acq;
      logic [2:0] gain;
      logic [1:0] res;
      logic [2:0] chan;
   } gpb_adc_cfg_s;
   localparam gpb_adc_cfg_s ADC_CFG_RST = '{acq: ACQ_10_CODE, gain: GAIN_1_6_CODE, res: RES_12_CODE, chan: 3'h0};
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } gpb_byte_s;
   typedef enum logic [1:0] {MODE_NONE, MODE_BRIDGE, MODE_COMMAND} gpb_mode_e;
   typedef enum logic [1:0] {ADC_IDLE, ADC_SAMPLE, ADC_CONVERT} gpb_adc_st_e;
endpackage : gpb_pkg

// File: logic/gpb_top.sv
// General pin function block: pins, PWM, square wave, converter front end, reset and straps
// Notes on behaviour
// - Nineteen pins, each with its own input or output direction bit.
// - Each output pin selects standard or high drive strength.
// - Each pin selects pull-up, pull-down or no pull.
// - Any pin can raise wake on a configured high or low level.
// - Converter selects one of eight channels and runs one conversion per request.
// - Result resolution is eight, ten or twelve bits.
// - Input gain 4, 2, 1, 1/3, 1/4, 1/5, 1/6; 1/6 after reset.
// - Sampling window 3, 5, 10, 15, 20 or 40 us; 10 us after reset.
// - Output pins may carry the PWM waveform through a per-pin select.
// - PWM frequency programmable up to 1 MHz, duty from zero to full.
// - Square wave on at most two pins, one frequency, separate duties.
// - Square wave frequency zero up to 4 MHz; a zero duty field gives half high half low.
// - Reset pin held low at least 100 ms causes a full reset.
// - Select strap high enables serial link; autorun strap high selects bridge.
// - Select strap high with autorun strap low selects command mode.
// - Bridge mode passes link data straight to the UART transmitter.
// - Command mode sends link data to the command interpreter, answers on link.
//
// Implementation choices: the strobed register port and the register addresses.
module gpb_top #(
   parameter int RESET_HOLD = gpb_pkg::RESET_HOLD_CYC
) (
   input  wire logic                             ref_clk_i,
   input  wire logic                             rst_n_i,
   input  wire logic [gpb_pkg::ADDR_W-1:0]       reg_addr_i,
   input  wire logic [gpb_pkg::DATA_W-1:0]       reg_wdata_i,
   input  wire logic                             reg_wr_i,
   input  wire logic                             reg_rd_i,
   output logic      [gpb_pkg::DATA_W-1:0]       reg_rdata_o,
   input  wire logic [gpb_pkg::NUM_PINS-1:0]     general_pin_i,
   output logic      [gpb_pkg::NUM_PINS-1:0]     general_pin_o,
   output logic      [gpb_pkg::NUM_PINS-1:0]     general_pin_oe_n_o,
   output logic      [gpb_pkg::NUM_PINS-1:0]     general_pin_hi_drive_o,
   output logic      [gpb_pkg::NUM_PINS-1:0]     general_pin_pull_up_o,
   output logic      [gpb_pkg::NUM_PINS-1:0]     general_pin_pull_down_o,
   output logic                                  wake_o,
   output logic                                  irq_o,
   output logic      [2:0]                       analog_input_channel_o,
   output logic      [2:0]                       adc_gain_o,
   output logic      [1:0]                       adc_res_o,
   output logic                                  adc_sample_o,
   output logic                                  adc_convert_o,
   input  wire logic                             adc_done_i,
   input  wire logic [gpb_pkg::ADC_RAW_W-1:0]    adc_raw_i,
   input  wire logic                             hardware_reset_low_i,
   input  wire logic                             link_service_select_strap_i,
   input  wire logic                             autorun_strap_low_i,
   output logic                                  full_reset_o,
   input  wire gpb_pkg::gpb_byte_s               link_rx_i,
   output gpb_pkg::gpb_byte_s                    uart_tx_o,
   output gpb_pkg::gpb_byte_s                    at_cmd_o,
   input  wire gpb_pkg::gpb_byte_s               at_resp_i,
   output gpb_pkg::gpb_byte_s                    link_tx_o
);
   import gpb_pkg::*;

   localparam int HOLD_W = $clog2(RESET_HOLD + 1);

   // ------------------------------------------------------------
   // Pin and strap synchronisers, reset hold filter
   // ------------------------------------------------------------
   logic [NUM_PINS-1:0] pin_s1_q, pin_s2_q;
   logic [2:0]          ext_s1_q, ext_s2_q;
   logic [HOLD_W-1:0]   hold_cnt_q, hold_cnt_d;
   logic                hold_rst_q, hold_rst_d;
   logic                srst;

   always_comb begin
      hold_cnt_d = hold_cnt_q;
      hold_rst_d = 1'b0;
      if (ext_s2_q[0]) begin
         hold_cnt_d = '0;
      end else if (hold_cnt_q == HOLD_W'(RESET_HOLD)) begin
         hold_rst_d = 1'b1;
      end else begin
         hold_cnt_d = hold_cnt_q + HOLD_W'(1);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
         ext_s1_q   <= 3'h1;
         ext_s2_q   <= 3'h1;
         hold_cnt_q <= '0;
         hold_rst_q <= 1'b0;
      end else begin
         pin_s1_q   <= general_pin_i;
         pin_s2_q   <= pin_s1_q;
         ext_s1_q   <= {autorun_strap_low_i, link_service_select_strap_i, hardware_reset_low_i};
         ext_s2_q   <= ext_s1_q;
         hold_cnt_q <= hold_cnt_d;
         hold_rst_q <= hold_rst_d;
      end
   end

   assign srst = !rst_n_i || hold_rst_q;

   // ------------------------------------------------------------
   // Configuration registers and engines
   // ------------------------------------------------------------
   logic [NUM_PINS-1:0]  dir_q, out_q, drv_q, pu_q, pd_q, wen_q, wpol_q, psel_q;
   logic [NUM_PINS-1:0]  dir_d, out_d, drv_d, pu_d, pd_d, wen_d, wpol_d, psel_d;
   logic [CNT_W-1:0]     pper_q, pduty_q, pper_s_q, pduty_s_q, pcnt_q;
   logic [CNT_W-1:0]     pper_d, pduty_d, pper_s_d, pduty_s_d, pcnt_d, pper_eff;
   logic [13:0]          sqcfg_q, sqcfg_d;
   logic [CNT_W-1:0]     sqper_q, sqcnt_q, sqper_d, sqcnt_d, sqduty_a, sqduty_b;
   logic [DATA_W-1:0]    sqduty_q, sqduty_d;
   gpb_adc_cfg_s         acfg_q, acfg_d;
   gpb_adc_st_e          ast_q, ast_d;
   logic [11:0]          acnt_q, acnt_d, acq_cyc;
   logic [ADC_RAW_W-1:0] ares_q, ares_d;
   logic [INT_W-1:0]     ist_q, ist_d, ien_q, ien_d, ev;
   logic                 wake_q, wake_d, pwm_q, pwm_d;
   logic                 taken_q, taken_d;
   logic [1:0]           swait_q, swait_d;
   gpb_mode_e            mode_q, mode_d;
   logic [DATA_W-1:0]    rdata_d;
   logic [NUM_PINS-1:0]  lvl_d, wake_hit;
   logic                 sq_a_lvl, sq_b_lvl;

   always_comb begin
      unique case (acfg_q.acq)
         3'h0:    acq_cyc = 12'(ACQ_3_CYC);
         3'h1:    acq_cyc = 12'(ACQ_5_CYC);
         3'h2:    acq_cyc = 12'(ACQ_10_CYC);
         3'h3:    acq_cyc = 12'(ACQ_15_CYC);
         3'h4:    acq_cyc = 12'(ACQ_20_CYC);
         default: acq_cyc = 12'(ACQ_40_CYC);
      endcase
   end

   assign pper_eff = (pper_s_q < CNT_W'(PWM_MIN_PER_CYC)) ? CNT_W'(PWM_MIN_PER_CYC) : pper_s_q;
   assign sqduty_a = (sqduty_q[CNT_W-1:0] == '0) ? (sqper_q >> 1) : sqduty_q[CNT_W-1:0];
   assign sqduty_b = (sqduty_q[SQ_DUTY_B_LSB +: CNT_W] == '0) ? (sqper_q >> 1)
                     : sqduty_q[SQ_DUTY_B_LSB +: CNT_W];
   assign sq_a_lvl = (sqper_q != '0) && (sqcnt_q < sqduty_a);
   assign sq_b_lvl = (sqper_q != '0) && (sqcnt_q < sqduty_b);

   always_comb begin
      dir_d     = dir_q;
      out_d     = out_q;
      drv_d     = drv_q;
      pu_d      = pu_q;
      pd_d      = pd_q;
      wen_d     = wen_q;
      wpol_d    = wpol_q;
      psel_d    = psel_q;
      pper_d    = pper_q;
      pduty_d   = pduty_q;
      sqcfg_d   = sqcfg_q;
      sqper_d   = sqper_q;
      sqduty_d  = sqduty_q;
      acfg_d    = acfg_q;
      ast_d     = ast_q;
      acnt_d    = acnt_q;
      ares_d    = ares_q;
      ien_d     = ien_q;
      ev        = '0;
      rdata_d   = '0;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            REG_DIR:      dir_d    = reg_wdata_i[NUM_PINS-1:0];
            REG_OUT:      out_d    = reg_wdata_i[NUM_PINS-1:0];
            REG_DRIVE:    drv_d    = reg_wdata_i[NUM_PINS-1:0];
            REG_PULL_UP:  pu_d     = reg_wdata_i[NUM_PINS-1:0];
            REG_PULL_DN:  pd_d     = reg_wdata_i[NUM_PINS-1:0];
            REG_WAKE_EN:  wen_d    = reg_wdata_i[NUM_PINS-1:0];
            REG_WAKE_POL: wpol_d   = reg_wdata_i[NUM_PINS-1:0];
            REG_PWM_SEL:  psel_d   = reg_wdata_i[NUM_PINS-1:0];
            REG_PWM_PER:  pper_d   = reg_wdata_i[CNT_W-1:0];
            REG_PWM_DUTY: pduty_d  = reg_wdata_i[CNT_W-1:0];
            REG_SQ_CFG:   sqcfg_d  = reg_wdata_i[13:0];
            REG_SQ_PER:   sqper_d  = (reg_wdata_i[CNT_W-1:0] != '0 && reg_wdata_i[CNT_W-1:0] < CNT_W'(SQ_MIN_PER_CYC))
                                     ? CNT_W'(SQ_MIN_PER_CYC) : reg_wdata_i[CNT_W-1:0];
            REG_SQ_DUTY:  sqduty_d = reg_wdata_i;
            REG_INT_EN:   ien_d    = reg_wdata_i[INT_W-1:0];
            REG_ADC_CTRL: begin
               if (ast_q == ADC_IDLE) begin
                  acfg_d = gpb_adc_cfg_s'(reg_wdata_i[10:0]);
                  if (reg_wdata_i[7:5] > GAIN_MAX_CODE) begin
                     acfg_d.gain = GAIN_MAX_CODE;
                  end
               end
            end
            default: ;
         endcase
      end
      // Converter sequence
      unique case (ast_q)
         ADC_IDLE: begin
            if (reg_wr_i && reg_addr_i == REG_ADC_CTRL && reg_wdata_i[ADC_START_BIT]) begin
               ast_d  = ADC_SAMPLE;
               acnt_d = '0;
            end
         end
         ADC_SAMPLE: begin
            acnt_d = acnt_q + 12'h001;
            if (acnt_q == acq_cyc - 12'h001) begin
               ast_d = ADC_CONVERT;
            end
         end
         ADC_CONVERT: begin
            if (adc_done_i) begin
               ast_d = ADC_IDLE;
               ev[INT_ADC_BIT] = 1'b1;
               unique case (acfg_q.res)
                  RES_8_CODE:  ares_d = {4'h0, adc_raw_i[11:4]};
                  RES_10_CODE: ares_d = {2'h0, adc_raw_i[11:2]};
                  default:     ares_d = adc_raw_i;
               endcase
            end
         end
      endcase
      if (wake_d && !wake_q) begin
         ev[INT_WAKE_BIT] = 1'b1;
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            REG_DIR:      rdata_d[NUM_PINS-1:0] = dir_q;
            REG_OUT:      rdata_d[NUM_PINS-1:0] = out_q;
            REG_IN:       rdata_d[NUM_PINS-1:0] = pin_s2_q;
            REG_DRIVE:    rdata_d[NUM_PINS-1:0] = drv_q;
            REG_PULL_UP:  rdata_d[NUM_PINS-1:0] = pu_q;
            REG_PULL_DN:  rdata_d[NUM_PINS-1:0] = pd_q;
            REG_WAKE_EN:  rdata_d[NUM_PINS-1:0] = wen_q;
            REG_WAKE_POL: rdata_d[NUM_PINS-1:0] = wpol_q;
            REG_PWM_SEL:  rdata_d[NUM_PINS-1:0] = psel_q;
            REG_PWM_PER:  rdata_d[CNT_W-1:0]    = pper_q;
            REG_PWM_DUTY: rdata_d[CNT_W-1:0]    = pduty_q;
            REG_SQ_CFG:   rdata_d[13:0]         = sqcfg_q;
            REG_SQ_PER:   rdata_d[CNT_W-1:0]    = sqper_q;
            REG_SQ_DUTY:  rdata_d               = sqduty_q;
            REG_ADC_CTRL: rdata_d[10:0]         = acfg_q;
            REG_ADC_DATA: rdata_d = {(ast_q != ADC_IDLE), 19'h00000, ares_q};
            REG_INT_STAT: rdata_d[INT_W-1:0]    = ist_q;
            REG_INT_EN:   rdata_d[INT_W-1:0]    = ien_q;
            REG_MODE:     rdata_d[2:0] = {mode_q == MODE_COMMAND, mode_q == MODE_BRIDGE, mode_q != MODE_NONE};
            default:      rdata_d = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Interrupt status, PWM and square wave counters, straps
   // ------------------------------------------------------------
   always_comb begin
      ist_d = ist_q;
      if (reg_wr_i && reg_addr_i == REG_INT_CLR) begin
         ist_d = ist_q & ~reg_wdata_i[INT_W-1:0];
      end
      ist_d = ist_d | ev;
      pcnt_d    = pcnt_q + CNT_W'(1);
      pper_s_d  = pper_s_q;
      pduty_s_d = pduty_s_q;
      if (pcnt_q >= pper_eff - CNT_W'(1)) begin
         pcnt_d    = '0;
         pper_s_d  = pper_q;
         pduty_s_d = pduty_q;
      end
      if (pduty_s_q == '0) begin
         pwm_d = 1'b0;
      end else if (pduty_s_q >= pper_eff) begin
         pwm_d = 1'b1;
      end else begin
         pwm_d = (pcnt_d < pduty_s_d);
      end
      sqcnt_d = sqcnt_q + CNT_W'(1);
      if (sqper_q == '0 || sqcnt_q >= sqper_q - CNT_W'(1)) begin
         sqcnt_d = '0;
      end
      taken_d = taken_q;
      swait_d = swait_q;
      mode_d  = mode_q;
      if (!taken_q) begin
         swait_d = swait_q + 2'h1;
         if (swait_q == 2'(STRAP_WAIT_CYC)) begin
            taken_d = 1'b1;
            if (!ext_s2_q[1]) begin
               mode_d = MODE_NONE;
            end else if (ext_s2_q[2]) begin
               mode_d = MODE_BRIDGE;
            end else begin
               mode_d = MODE_COMMAND;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Per-pin output select and wake detect
   // ------------------------------------------------------------
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_comb begin
         if (sqcfg_q[SQ_A_EN_BIT] && sqcfg_q[SQ_A_IDX_LSB +: PIN_IDX_W] == PIN_IDX_W'(i)) begin
            lvl_d[i] = sq_a_lvl;
         end else if (sqcfg_q[SQ_B_EN_BIT] && sqcfg_q[SQ_B_IDX_LSB +: PIN_IDX_W] == PIN_IDX_W'(i)) begin
            lvl_d[i] = sq_b_lvl;
         end else if (psel_q[i]) begin
            lvl_d[i] = pwm_q;
         end else begin
            lvl_d[i] = out_q[i];
         end
         wake_hit[i] = wen_q[i] && (pin_s2_q[i] == wpol_q[i]);
      end
   end
   assign wake_d = |wake_hit;

   always_ff @(posedge ref_clk_i) begin
      if (srst) begin
         dir_q     <= '0;
         out_q     <= '0;
         drv_q     <= '0;
         pu_q      <= '0;
         pd_q      <= '0;
         wen_q     <= '0;
         wpol_q    <= '0;
         psel_q    <= '0;
         pper_q    <= '0;
         pduty_q   <= '0;
         pper_s_q  <= '0;
         pduty_s_q <= '0;
         pcnt_q    <= '0;
         sqcfg_q   <= '0;
         sqper_q   <= '0;
         sqcnt_q   <= '0;
         sqduty_q  <= '0;
         acfg_q    <= ADC_CFG_RST;
         ast_q     <= ADC_IDLE;
         acnt_q    <= '0;
         ares_q    <= '0;
         ist_q     <= '0;
         ien_q     <= '0;
         wake_q    <= 1'b0;
         pwm_q     <= 1'b0;
         taken_q   <= 1'b0;
         swait_q   <= '0;
         mode_q    <= MODE_NONE;
         reg_rdata_o             <= '0;
         general_pin_o           <= '0;
         general_pin_oe_n_o      <= '1;
         general_pin_hi_drive_o  <= '0;
         general_pin_pull_up_o   <= '0;
         general_pin_pull_down_o <= '0;
         wake_o                  <= 1'b0;
         irq_o                   <= 1'b0;
         analog_input_channel_o  <= '0;
         adc_gain_o              <= GAIN_1_6_CODE;
         adc_res_o               <= RES_12_CODE;
         adc_sample_o            <= 1'b0;
         adc_convert_o           <= 1'b0;
         uart_tx_o               <= '0;
         at_cmd_o                <= '0;
         link_tx_o               <= '0;
         full_reset_o            <= hold_rst_q;
      end else begin
         dir_q     <= dir_d;
         out_q     <= out_d;
         drv_q     <= drv_d;
         pu_q      <= pu_d;
         pd_q      <= pd_d;
         wen_q     <= wen_d;
         wpol_q    <= wpol_d;
         psel_q    <= psel_d;
         pper_q    <= pper_d;
         pduty_q   <= pduty_d;
         pper_s_q  <= pper_s_d;
         pduty_s_q <= pduty_s_d;
         pcnt_q    <= pcnt_d;
         sqcfg_q   <= sqcfg_d;
         sqper_q   <= sqper_d;
         sqcnt_q   <= sqcnt_d;
         sqduty_q  <= sqduty_d;
         acfg_q    <= acfg_d;
         ast_q     <= ast_d;
         acnt_q    <= acnt_d;
         ares_q    <= ares_d;
         ist_q     <= ist_d;
         ien_q     <= ien_d;
         wake_q    <= wake_d;
         pwm_q     <= pwm_d;
         taken_q   <= taken_d;
         swait_q   <= swait_d;
         mode_q    <= mode_d;
         reg_rdata_o             <= rdata_d;
         general_pin_o           <= lvl_d & dir_q;
         general_pin_oe_n_o      <= ~dir_q;
         general_pin_hi_drive_o  <= drv_q & dir_q;
         general_pin_pull_up_o   <= pu_q;
         general_pin_pull_down_o <= pd_q & ~pu_q;
         wake_o                  <= wake_d;
         irq_o                   <= |(ist_d & ien_d);
         analog_input_channel_o  <= acfg_q.chan;
         adc_gain_o              <= acfg_q.gain;
         adc_res_o               <= acfg_q.res;
         adc_sample_o            <= (ast_d == ADC_SAMPLE);
         adc_convert_o           <= (ast_d == ADC_CONVERT);
         uart_tx_o               <= (mode_q == MODE_BRIDGE) ? link_rx_i : '0;
         at_cmd_o                <= (mode_q == MODE_COMMAND) ? link_rx_i : '0;
         link_tx_o               <= (mode_q == MODE_COMMAND) ? at_resp_i : '0;
         full_reset_o            <= 1'b0;
      end
   end
endmodule : gpb_top

// File: sim/gpb_board_model.sv
// Board model: pins with pulls, converter answering conversions
module gpb_board_model import gpb_pkg::*; (
   input  wire logic                ref_clk_i,
   input  wire logic [NUM_PINS-1:0] pin_o_i,
   input  wire logic [NUM_PINS-1:0] pin_oe_n_i,
   input  wire logic [NUM_PINS-1:0] pull_up_i,
   input  wire logic [NUM_PINS-1:0] pull_dn_i,
   input  wire logic                adc_convert_i,
   output logic      [NUM_PINS-1:0] pin_o,
   output logic                     adc_done_o,
   output logic      [ADC_RAW_W-1:0] adc_raw_o
);
   logic [NUM_PINS-1:0] float_q = '0;
   logic [3:0]          wait_q = '0;
   always @(posedge ref_clk_i) float_q <= ~float_q;
   assign pin_o = ~pin_oe_n_i & pin_o_i | pin_oe_n_i & (pull_up_i | ~pull_dn_i & float_q);
   always @(posedge ref_clk_i) wait_q <= adc_convert_i && !adc_done_o ? wait_q + 4'h1 : 4'h0;
   assign adc_done_o = wait_q == 4'h5;
   assign adc_raw_o = adc_done_o ? 12'habc : 12'h543;
endmodule : gpb_board_model

// File: sim/gpb_props.sv
// Port checker of the general pin function block
module gpb_props import gpb_pkg::*; (
   input wire logic                ref_clk_i,
   input wire logic                rst_n_i,
   input wire logic                reg_rd_i,
   input wire logic [DATA_W-1:0]   reg_rdata_o,
   input wire logic [NUM_PINS-1:0] general_pin_oe_n_o,
   input wire logic [2:0]          adc_gain_o,
   input wire logic                adc_sample_o,
   input wire logic                adc_convert_o,
   input wire logic                adc_done_i,
   input wire gpb_byte_s           link_rx_i,
   input wire gpb_byte_s           uart_tx_o,
   input wire gpb_byte_s           at_cmd_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [15:0] acq_q, acq_d;
   always_comb acq_d = adc_sample_o ? acq_q + 16'h1 : 16'h0;
   always_ff @(posedge ref_clk_i) acq_q <= rst_n_i ? acq_d : 16'h0;
   sequence conv_end_s; adc_convert_o && adc_done_i; endsequence
   rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0) else $error("stray read data");
   bridge_copy_a: assert property (uart_tx_o.valid |-> uart_tx_o == $past(link_rx_i)) else $error("uart");
   cmd_copy_a: assert property (at_cmd_o.valid |-> at_cmd_o == $past(link_rx_i)) else $error("cmd");
   one_path_a: assert property (!(uart_tx_o.valid && at_cmd_o.valid)) else $error("two paths");
   sample_convert_a: assert property ($fell(adc_sample_o) |-> adc_convert_o) else $error("no convert");
   phase_excl_a: assert property (adc_sample_o |-> !adc_convert_o) else $error("phases overlap");
   done_ends_a: assert property (conv_end_s |=> !adc_convert_o) else $error("convert stuck");
   acq_len_a: assert property ($fell(adc_sample_o) |-> acq_q inside {ACQ_3_CYC, ACQ_5_CYC, ACQ_10_CYC,
      ACQ_15_CYC, ACQ_20_CYC, ACQ_40_CYC}) else $error("bad window");
   rst_vals_a: assert property (disable iff (1'b0) !rst_n_i |=> general_pin_oe_n_o == '1
      && adc_gain_o == GAIN_1_6_CODE) else $error("reset values");
endmodule : gpb_props

// File: sim/tb_general_pin_function_block.sv
// Testbench of the general pin function block
module tb_general_pin_function_block;
   timeunit 1ns;
   timeprecision 1ns;
   import gpb_pkg::*;
   logic ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, adc_done_i, wake_o, irq_o, full_reset_o;
   logic hardware_reset_low_i = 1, link_service_select_strap_i = 1, autorun_strap_low_i = 1;
   logic adc_sample_o, adc_convert_o;
   logic [ADDR_W-1:0] reg_addr_i = '0;
   logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o;
   logic [NUM_PINS-1:0] general_pin_i, general_pin_o, general_pin_oe_n_o, general_pin_hi_drive_o;
   logic [NUM_PINS-1:0] general_pin_pull_up_o, general_pin_pull_down_o;
   logic [2:0] analog_input_channel_o, adc_gain_o;
   logic [1:0] adc_res_o;
   logic [ADC_RAW_W-1:0] adc_raw_i;
   gpb_byte_s link_rx_i = '0, at_resp_i = '0, uart_tx_o, at_cmd_o, link_tx_o;
   int fails = 0, samples_checked = 0, n;
   int duty [3] = '{0, 100, 25};
   gpb_top #(.RESET_HOLD(20)) gpb_top_inst (.*);
   gpb_board_model gpb_board_model_inst (.ref_clk_i, .pin_o_i(general_pin_o), .pin_oe_n_i(general_pin_oe_n_o),
      .pull_up_i(general_pin_pull_up_o), .pull_dn_i(general_pin_pull_down_o), .adc_convert_i(adc_convert_o),
      .pin_o(general_pin_i), .adc_done_o(adc_done_i), .adc_raw_o(adc_raw_i));
   initial forever #5 ref_clk_i = ~ref_clk_i;
   task give_verdict();
      $display("fails %0d samples_checked %0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   task chk(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      repeat (4) @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk(reg_rdata_o, e);
   endtask : rd
   task ones(int b, int c);
      n = 0;
      repeat (c) @(negedge ref_clk_i) n += general_pin_o[b];
   endtask : ones
   task lnk(logic [26:0] e);
      @(posedge ref_clk_i);
      link_rx_i <= '{1'b1, 8'h3c};
      at_resp_i <= '{1'b1, 8'hc3};
      @(posedge ref_clk_i);
      link_rx_i <= '0;
      at_resp_i <= '0;
      @(negedge ref_clk_i);
      chk({uart_tx_o, at_cmd_o, link_tx_o}, {5'h0, e});
   endtask : lnk
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(REG_MODE, 32'h3);
      rd(REG_ADC_CTRL, 32'h2d0);
      rd(8'hfc, 32'h0);
      lnk({9'h13c, 18'h0});
      wr(REG_PULL_UP, 32'h7ffff);
      rd(REG_IN, 32'h7ffff);
      wr(REG_INT_EN, 32'h3);
      wr(REG_WAKE_POL, 32'h1);
      wr(REG_WAKE_EN, 32'h1);
      rd(REG_INT_STAT, 32'h1);
      chk({wake_o, irq_o}, 32'h3);
      wr(REG_INT_EN, 32'h2);
      wr(REG_INT_CLR, 32'h1);
      rd(REG_INT_STAT, 32'h0);
      chk(irq_o, 32'h0);
      wr(REG_DIR, 32'h7ffff);
      wr(REG_OUT, 32'h5a5a5);
      wr(REG_DRIVE, 32'h00f0f);
      rd(REG_IN, 32'h5a5a5);
      chk({general_pin_hi_drive_o, general_pin_oe_n_o}, {19'h00f0f, 19'h0});
      wr(REG_PWM_SEL, 32'h2);
      wr(REG_PWM_PER, 32'h64);
      foreach (duty[i]) begin
         wr(REG_PWM_DUTY, duty[i]);
         repeat (250) @(posedge ref_clk_i);
         ones(1, 200);
         chk(n, duty[i] * 2);
      end
      wr(REG_SQ_PER, 32'h28);
      wr(REG_SQ_DUTY, 32'h000a0000);
      wr(REG_SQ_CFG, 32'h2322);
      repeat (100) @(posedge ref_clk_i);
      ones(2, 400);
      chk(n, 200);
      ones(3, 400);
      chk(n, 100);
      wr(REG_ADC_CTRL, 32'h80000005);
      repeat (2) @(negedge ref_clk_i);
      chk({analog_input_channel_o, adc_gain_o, adc_res_o}, 32'ha0);
      for (n = 0; irq_o !== 1'b1 && n < 2000; n++) @(negedge ref_clk_i);
      rd(REG_ADC_DATA, 32'hab);
      autorun_strap_low_i <= 1'b0;
      hardware_reset_low_i <= 1'b0;
      repeat (30) @(posedge ref_clk_i);
      chk(full_reset_o, 32'h1);
      hardware_reset_low_i <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      rd(REG_MODE, 32'h5);
      rd(REG_DIR, 32'h0);
      lnk({9'h0, 9'h13c, 9'h1c3});
      give_verdict();
   end
endmodule : tb_general_pin_function_block
bind gpb_top gpb_props gpb_props_inst (.ref_clk_i, .rst_n_i, .reg_rd_i, .reg_rdata_o, .general_pin_oe_n_o,
   .adc_gain_o, .adc_sample_o, .adc_convert_o, .adc_done_i, .link_rx_i, .uart_tx_o, .at_cmd_o);
